/* File: design/mpio_pkg.sv */
// Package: constants, register map and types for the meter pulse I/O block
package mpio_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ           = 40000000;
  localparam int unsigned PULSE_ON_MS      = 500;
  localparam int unsigned PULSE_PERIOD_MS  = 1000;   // 1 Hz maximum rate
  localparam int unsigned LONG_PRESS_MS    = 2000;
  localparam int unsigned JOIN_DELAY_S     = 30;
  localparam int unsigned PULSE_ON_CYC     = CLK_HZ / 1000 * PULSE_ON_MS;
  localparam int unsigned PULSE_PERIOD_CYC = CLK_HZ / 1000 * PULSE_PERIOD_MS;
  localparam int unsigned LONG_PRESS_CYC   = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int unsigned JOIN_DELAY_CYC   = CLK_HZ * JOIN_DELAY_S;

  // ==========================================================================
  // Baud rates
  // ==========================================================================
  localparam int unsigned OPT_BAUD         = 2400;
  localparam int unsigned BUS_BAUD_LOW     = 300;
  localparam int unsigned BUS_BAUD_HIGH    = 2400;
  localparam int unsigned OPT_BIT_CYC      = CLK_HZ / OPT_BAUD;
  localparam int unsigned BUS_BIT_CYC_LOW  = CLK_HZ / BUS_BAUD_LOW;
  localparam int unsigned BUS_BIT_CYC_HIGH = CLK_HZ / BUS_BAUD_HIGH;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FACTOR1   = 8'h04;
  localparam logic [7:0] REG_FACTOR2   = 8'h08;
  localparam logic [7:0] REG_AUX_TOT1  = 8'h0C;
  localparam logic [7:0] REG_AUX_TOT2  = 8'h10;
  localparam logic [7:0] REG_PRIM_ADDR = 8'h14;
  localparam logic [7:0] REG_SEC_ADDR  = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1C;
  localparam logic [7:0] REG_JOIN      = 8'h20;
  localparam logic [7:0] REG_BAUD      = 8'h24;

  // CTRL fields
  localparam int unsigned CTRL_COMBINED_BIT = 0;  // heating and cooling
  // JOIN fields (write 1 to request)
  localparam int unsigned JOIN_NOW_BIT      = 0;
  localparam int unsigned JOIN_DLY_BIT      = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] FACTOR_RST    = 16'h0001;  // one pulse per unit
  localparam logic [7:0]  PRIM_ADDR_RST = 8'h00;
  localparam logic [31:0] SERIAL_NUM    = 32'h0000_1234; // arbitrary value

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MPIO_PRESS_NONE,
    MPIO_PRESS_SHORT,
    MPIO_PRESS_LONG
  } mpio_press_t;

  typedef struct packed {
    logic heat_inc;
    logic cool_inc;
    logic vol_inc;
  } mpio_disp_inc_t;

  typedef struct packed {
    logic        join_req;
    logic        join_delayed;
    logic [1:0]  menu_state;
  } mpio_join_stat_t;

endpackage : mpio_pkg

/* File: design/mpio_pulse_gen.sv */
// Paced open-collector pulse output with pending count
`timescale 1ns/1ps
module mpio_pulse_gen
  import mpio_pkg::*;
#(
  parameter int unsigned PEND_W     = 8,
  parameter int unsigned ON_CYC     = PULSE_ON_CYC,
  parameter int unsigned PERIOD_CYC = PULSE_PERIOD_CYC
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              inc,
  output logic                   pulse_oe,
  output logic [PEND_W-1:0]      pending
);

  // ==========================================================================
  // Pending count and pacing
  // ==========================================================================
  logic [PEND_W-1:0] pend_ff;
  logic [31:0]       tmr_ff;
  logic              busy_ff;
  logic              oe_ff;
  logic              start;

  // Saturates rather than wrapping so a burst never loses count to zero
  assign start = !busy_ff && (pend_ff != '0); // RL16

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_ff <= '0;
    end else if (inc && !start && (pend_ff != '1)) begin
      pend_ff <= pend_ff + 1'b1; // RL16
    end else if (start && !inc) begin
      pend_ff <= pend_ff - 1'b1; // RL6
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_ff  <= '0;
      busy_ff <= 1'b0;
      oe_ff   <= 1'b0;
    end else if (start) begin
      tmr_ff  <= 32'(PERIOD_CYC - 1);
      busy_ff <= 1'b1;
      oe_ff   <= 1'b1; // RL7
    end else if (busy_ff) begin
      tmr_ff  <= tmr_ff - 32'h1;
      busy_ff <= (tmr_ff != 32'h0);
      oe_ff   <= (tmr_ff > 32'(PERIOD_CYC - ON_CYC)); // RL7
    end
  end

  assign pulse_oe = oe_ff;
  assign pending  = pend_ff;

endmodule // mpio_pulse_gen

/* File: design/mpio_aux_counter.sv */
// Auxiliary pulse input: synchroniser, edge detect and scaled totalizer
`timescale 1ns/1ps
module mpio_aux_counter
  import mpio_pkg::*;
#(
  parameter int unsigned TOT_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              pin_in,
  input  wire logic [15:0]       factor,
  input  wire logic              clr,
  output logic [TOT_W-1:0]       total
);

  // ==========================================================================
  // Input path
  // ==========================================================================
  logic        s1_ff, s2_ff, s3_ff;
  logic [15:0] frac_ff;
  logic [TOT_W-1:0] tot_ff;
  logic        edge_in;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign edge_in = s2_ff && !s3_ff;

  // ==========================================================================
  // Scaled totalizer: factor pulses make one unit; zero treated as one
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frac_ff <= '0;
      tot_ff  <= '0;
    end else if (clr) begin
      frac_ff <= '0;
      tot_ff  <= '0;
    end else if (edge_in) begin
      if (frac_ff + 16'h1 >= factor) begin
        frac_ff <= '0;
        tot_ff  <= tot_ff + 1'b1; // RL2
      end else begin
        frac_ff <= frac_ff + 16'h1; // RL2
      end
    end
  end

  assign total = tot_ff;

endmodule // mpio_aux_counter

/* File: design/mpio_top.sv */
// Top: meter pulse I/O, communication options and join menu, APB slave
//
// Notes on behaviour
// RL1: Two external meters are counted, each into its own totalizer.
// RL2: Each input has its own pulse factor, one pulse per unit at reset.
// RL3: Both totals are held apart, shown on the display and bus-readable.
// RL4: In single mode output one carries energy and output two volume.
// RL5: In combined mode output one is heating and output two cooling energy.
// RL6: Every least-digit step of an assigned quantity sends one pulse.
// RL7: A pulse is active 500 ms and pulses come at most once per second.
// RL8: The optical port runs fixed at 2400 baud.
// RL9: The meter-bus primary address is 0 after reset.
// RL10: The secondary address starts as the serial number and is writable.
// RL11: The meter-bus runs at 300 or 2400 baud only.
// RL12: The primary address is presented to the service menu display.
// RL13: A button hold over 2 s is a long press, otherwise a short one.
// RL14: A join may be started by software or by the button menu.
// RL15: In network-off, long press joins now, short press arms a 30 s join; here long press opens an offer, then long joins, short then long arms.
// RL16: Pending pulse counts keep fast increments from being lost; here an increment is dropped while the pending count is at its maximum.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mpio_top
  import mpio_pkg::*;
#(
  parameter int unsigned TOT_W          = 32,
  parameter int unsigned PEND_W         = 8,
  parameter int unsigned PULSE_ON       = PULSE_ON_CYC,
  parameter int unsigned PULSE_PERIOD   = PULSE_PERIOD_CYC,
  parameter int unsigned LONG_PRESS     = LONG_PRESS_CYC,
  parameter int unsigned JOIN_DELAY     = JOIN_DELAY_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 aux_in_one,
  input  wire logic                 aux_in_two,
  input  wire mpio_disp_inc_t       disp_inc,
  input  wire logic                 nav_button,
  input  wire logic                 menu_at_network_off,
  output logic                      pulse_out_first,
  output logic                      pulse_out_second,
  output logic [TOT_W-1:0]          aux_total_one,
  output logic [TOT_W-1:0]          aux_total_two,
  output logic [7:0]                svc_prim_addr,
  output logic [31:0]               opt_bit_cycles,
  output logic [31:0]               bus_bit_cycles,
  output logic                      join_immediate,
  output logic                      join_delayed,
  output mpio_press_t               press_evt
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic        combined_ff;
  logic [15:0] factor1_ff, factor2_ff;
  logic [7:0]  prim_addr_ff;
  logic [31:0] sec_addr_ff;
  logic        bus_fast_ff;
  logic        sw_join_now, sw_join_dly, clr1, clr2;
  logic        wr_en, rd_en;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      combined_ff  <= 1'b0;
      factor1_ff   <= FACTOR_RST; // RL2
      factor2_ff   <= FACTOR_RST; // RL2
      prim_addr_ff <= PRIM_ADDR_RST; // RL9
      sec_addr_ff  <= SERIAL_NUM; // RL10
      bus_fast_ff  <= 1'b1;
    end else if (wr_en) begin
      unique case (paddr)
        REG_CTRL:      combined_ff  <= pwdata[CTRL_COMBINED_BIT];
        REG_FACTOR1:   factor1_ff   <= pwdata[15:0];
        REG_FACTOR2:   factor2_ff   <= pwdata[15:0];
        REG_PRIM_ADDR: prim_addr_ff <= pwdata[7:0];
        REG_SEC_ADDR:  sec_addr_ff  <= pwdata; // RL10
        REG_BAUD:      bus_fast_ff  <= pwdata[0]; // RL11
        default: ;
      endcase
    end
  end

  // Writing a total register clears that total
  assign clr1        = wr_en && (paddr == REG_AUX_TOT1);
  assign clr2        = wr_en && (paddr == REG_AUX_TOT2);
  assign sw_join_now = wr_en && (paddr == REG_JOIN) && pwdata[JOIN_NOW_BIT];
  assign sw_join_dly = wr_en && (paddr == REG_JOIN) && pwdata[JOIN_DLY_BIT];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_CTRL) || (a == REG_FACTOR1) || (a == REG_FACTOR2) ||
             (a == REG_AUX_TOT1) || (a == REG_AUX_TOT2) ||
             (a == REG_PRIM_ADDR) || (a == REG_SEC_ADDR) ||
             (a == REG_STATUS) || (a == REG_JOIN) || (a == REG_BAUD);
  endfunction

  assign pslverr = psel && penable && !mapped(paddr);

  // ==========================================================================
  // Auxiliary inputs
  // ==========================================================================
  mpio_aux_counter #(.TOT_W(TOT_W)) u_aux1 (
    .clk    (clk),
    .rstn   (rstn),
    .pin_in (aux_in_one),
    .factor (factor1_ff),
    .clr    (clr1),
    .total  (aux_total_one)          // RL1 RL3
  );

  mpio_aux_counter #(.TOT_W(TOT_W)) u_aux2 (
    .clk    (clk),
    .rstn   (rstn),
    .pin_in (aux_in_two),
    .factor (factor2_ff),
    .clr    (clr2),
    .total  (aux_total_two)          // RL1 RL3
  );

  // ==========================================================================
  // Pulse outputs
  // ==========================================================================
  logic              inc_first, inc_second;
  logic [PEND_W-1:0] pend1, pend2;

  // Single mode merges heat and cool steps since only one is live
  assign inc_first  = combined_ff ? disp_inc.heat_inc
                    : (disp_inc.heat_inc | disp_inc.cool_inc); // RL4 RL5
  assign inc_second = combined_ff ? disp_inc.cool_inc
                    : disp_inc.vol_inc; // RL4 RL5

  mpio_pulse_gen #(
    .PEND_W    (PEND_W),
    .ON_CYC    (PULSE_ON),
    .PERIOD_CYC(PULSE_PERIOD)
  ) u_pg1 (
    .clk      (clk),
    .rstn     (rstn),
    .inc      (inc_first),
    .pulse_oe (pulse_out_first),
    .pending  (pend1)
  );

  mpio_pulse_gen #(
    .PEND_W    (PEND_W),
    .ON_CYC    (PULSE_ON),
    .PERIOD_CYC(PULSE_PERIOD)
  ) u_pg2 (
    .clk      (clk),
    .rstn     (rstn),
    .inc      (inc_second),
    .pulse_oe (pulse_out_second),
    .pending  (pend2)
  );

  // ==========================================================================
  // Communication rates and service display
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opt_bit_cycles <= '0;
      bus_bit_cycles <= '0;
      svc_prim_addr  <= '0;
    end else begin
      opt_bit_cycles <= 32'(OPT_BIT_CYC); // RL8
      bus_bit_cycles <= bus_fast_ff ? 32'(BUS_BIT_CYC_HIGH)
                                    : 32'(BUS_BIT_CYC_LOW); // RL11
      svc_prim_addr  <= prim_addr_ff; // RL12
    end
  end

  // ==========================================================================
  // Button classification
  // ==========================================================================
  logic        b1_ff, b2_ff, b3_ff;
  logic [31:0] hold_ff;
  mpio_press_t press_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b1_ff <= 1'b0;
      b2_ff <= 1'b0;
      b3_ff <= 1'b0;
    end else begin
      b1_ff <= nav_button;
      b2_ff <= b1_ff;
      b3_ff <= b2_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_ff  <= '0;
      press_ff <= MPIO_PRESS_NONE;
    end else begin
      press_ff <= MPIO_PRESS_NONE;
      if (b3_ff) begin
        if (hold_ff != '1) begin
          hold_ff <= hold_ff + 32'h1;
        end
      end else begin
        hold_ff <= '0;
      end
      if (b3_ff && !b2_ff) begin
        press_ff <= (hold_ff > 32'(LONG_PRESS)) ? MPIO_PRESS_LONG
                                                : MPIO_PRESS_SHORT; // RL13
      end
    end
  end

  assign press_evt = press_ff;

  // ==========================================================================
  // Join menu
  // ==========================================================================
  typedef enum logic [1:0] {
    MPIO_J_IDLE,
    MPIO_J_OFFER,
    MPIO_J_DELAY_SEL,
    MPIO_J_COUNT
  } mpio_jstate_t;

  mpio_jstate_t jst_ff;
  logic [31:0]  jdly_ff;
  logic         jnow_ff, jdel_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      jst_ff  <= MPIO_J_IDLE;
      jdly_ff <= '0;
      jnow_ff <= 1'b0;
      jdel_ff <= 1'b0;
    end else begin
      jnow_ff <= 1'b0;
      jdel_ff <= 1'b0;
      unique case (jst_ff)
        MPIO_J_IDLE: begin
          if (sw_join_now) begin
            jnow_ff <= 1'b1; // RL14
          end else if (sw_join_dly) begin
            jdly_ff <= 32'(JOIN_DELAY);
            jst_ff  <= MPIO_J_COUNT; // RL14
          end else if (menu_at_network_off &&
                       press_ff == MPIO_PRESS_LONG) begin
            jst_ff <= MPIO_J_OFFER; // RL15
          end
        end
        MPIO_J_OFFER: begin
          if (press_ff == MPIO_PRESS_LONG) begin
            jnow_ff <= 1'b1; // RL15
            jst_ff  <= MPIO_J_IDLE;
          end else if (press_ff == MPIO_PRESS_SHORT) begin
            jst_ff <= MPIO_J_DELAY_SEL; // RL15
          end
        end
        MPIO_J_DELAY_SEL: begin
          if (press_ff == MPIO_PRESS_LONG) begin
            jdly_ff <= 32'(JOIN_DELAY);
            jst_ff  <= MPIO_J_COUNT; // RL15
          end else if (press_ff == MPIO_PRESS_SHORT) begin
            jst_ff <= MPIO_J_IDLE;
          end
        end
        MPIO_J_COUNT: begin
          if (jdly_ff <= 32'h1) begin
            jdel_ff <= 1'b1; // RL15
            jst_ff  <= MPIO_J_IDLE;
          end else begin
            jdly_ff <= jdly_ff - 32'h1;
          end
        end
      endcase
    end
  end

  assign join_immediate = jnow_ff;
  assign join_delayed   = jdel_ff;

  // ==========================================================================
  // Read data
  // ==========================================================================
  always_comb begin
    prdata = 32'h0;
    if (rd_en) begin
      unique case (paddr)
        REG_CTRL:      prdata = {31'h0, combined_ff};
        REG_FACTOR1:   prdata = {16'h0, factor1_ff};
        REG_FACTOR2:   prdata = {16'h0, factor2_ff};
        REG_AUX_TOT1:  prdata = 32'(aux_total_one); // RL3
        REG_AUX_TOT2:  prdata = 32'(aux_total_two); // RL3
        REG_PRIM_ADDR: prdata = {24'h0, prim_addr_ff};
        REG_SEC_ADDR:  prdata = sec_addr_ff;
        REG_STATUS:    prdata = {8'h0, pend2[7:0], pend1[7:0], 4'h0,
                                 2'(jst_ff), pulse_out_second,
                                 pulse_out_first};
        REG_BAUD:      prdata = {31'h0, bus_fast_ff};
        default:       prdata = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  prim_addr_rst_a: assert property (@(posedge clk) // RL9
    $rose(rstn) |-> prim_addr_ff == 8'h00)
    else $error("primary address not zero after reset");

  logic [31:0] on_cnt_ff;

  // Width is far beyond any repetition count, so it is counted here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_cnt_ff <= '0;
    end else if (pulse_out_first) begin
      on_cnt_ff <= on_cnt_ff + 32'h1;
    end else begin
      on_cnt_ff <= '0;
    end
  end

  pulse_width_a: assert property (@(posedge clk) disable iff (!rstn) // RL7
    $fell(pulse_out_first) |-> on_cnt_ff == 32'(PULSE_ON))
    else $error("pulse output width wrong");

  pulse_route_a: assert property (@(posedge clk) disable iff (!rstn) // RL5
    combined_ff && disp_inc.cool_inc |-> inc_second)
    else $error("cooling step not routed to second output");

  vol_route_a: assert property (@(posedge clk) disable iff (!rstn) // RL4
    !combined_ff && disp_inc.vol_inc |-> inc_second && !inc_first ||
    disp_inc.heat_inc || disp_inc.cool_inc)
    else $error("volume step misrouted");

  opt_rate_a: assert property (@(posedge clk) disable iff (!rstn) // RL8
    $past(rstn) |-> opt_bit_cycles == 32'(OPT_BIT_CYC))
    else $error("optical rate changed");

  bus_rate_a: assert property (@(posedge clk) disable iff (!rstn) // RL11
    $past(rstn) |-> bus_bit_cycles == 32'(BUS_BIT_CYC_HIGH) ||
    bus_bit_cycles == 32'(BUS_BIT_CYC_LOW))
    else $error("illegal bus rate");

  join_offer_a: assert property (@(posedge clk) disable iff (!rstn) // RL15
    jst_ff == MPIO_J_OFFER && press_ff == MPIO_PRESS_LONG
    |=> join_immediate)
    else $error("long press did not join now");

  pending_keep_a: assert property (@(posedge clk) disable iff (!rstn) // RL16
    inc_first && pulse_out_first && pend1 != '1 |=> pend1 != '0)
    else $error("increment lost while pulsing");

  pending_two_a: assert property (@(posedge clk) disable iff (!rstn) // RL16
    inc_second && pulse_out_second && pend2 != '1 |=> pend2 != '0)
    else $error("increment lost on second output");

endmodule // mpio_top

/* File: sim/mpio_ext_meter.sv */
// Partner model: external meter that sends contact pulses to an aux input
`timescale 1ns/1ps
module mpio_ext_meter (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [7:0] n_pulse,
  output logic            pin,
  output logic            busy
);
  logic [7:0] left_ff;
  logic [2:0] ph_ff;
  // Each level lasts three cycles, above the two-flop synchroniser minimum
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left_ff <= 8'h00;
      ph_ff   <= 3'h0;
    end else if (start) begin
      left_ff <= n_pulse;
      ph_ff   <= 3'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff   <= (ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
      left_ff <= (ph_ff == 3'h5) ? left_ff - 8'h01 : left_ff;
    end
  end
  // Contact is open between frames, so the pin rests low
  assign pin  = (left_ff != 8'h00) && (ph_ff < 3'h3);
  assign busy = (left_ff != 8'h00);
endmodule // mpio_ext_meter

/* File: sim/meter_pulse_io_and_comm_options_test.sv */
// Testbench: self-checking random and corner tests of the pulse I/O block
`timescale 1ns/1ps
module meter_pulse_io_and_comm_options_test;
  import mpio_pkg::*;
  localparam int ON = 5;
  localparam int PER = 10;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        aux_in_one, aux_in_two, nav_button, menu_at_network_off;
  logic        pulse_out_first, pulse_out_second, join_immediate;
  logic        join_delayed, go, busy1, busy2;
  logic [7:0]  paddr, svc_prim_addr, k1, k2;
  logic [31:0] pwdata, prdata, q, r, f1, f2, aux_total_one, aux_total_two;
  logic [31:0] opt_bit_cycles, bus_bit_cycles;
  logic [1:0]  po_q;
  mpio_disp_inc_t disp_inc;
  mpio_press_t    press_evt, last_press;
  int          fail_count, n_tests, cycles, seed, n_jn, n_jd;
  int          hi[2], since[2], rises[2];

  mpio_top #(.PULSE_ON(ON), .PULSE_PERIOD(PER), .LONG_PRESS(20),
    .JOIN_DELAY(30)) u_mpio_top (.clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .aux_in_one, .aux_in_two,
    .disp_inc, .nav_button, .menu_at_network_off, .pulse_out_first,
    .pulse_out_second, .aux_total_one, .aux_total_two, .svc_prim_addr,
    .opt_bit_cycles, .bus_bit_cycles, .join_immediate, .join_delayed,
    .press_evt);
  mpio_ext_meter u_mpio_ext_meter (.clk, .rstn, .start(go), .n_pulse(k1),
    .pin(aux_in_one), .busy(busy1));
  mpio_ext_meter u_mpio_ext_meter_two (.clk, .rstn, .start(go),
    .n_pulse(k2), .pin(aux_in_two), .busy(busy2));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic press(input int n);
    @(posedge clk);
    nav_button <= 1'b1;
    repeat (n) @(posedge clk);
    nav_button <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic inc(input logic [2:0] v, input int n);
    @(posedge clk);
    disp_inc <= v;
    repeat (n) @(posedge clk);
    disp_inc <= 3'h0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Monitors and hang limit
  // ==========================================================================
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
    for (int i = 0; i < 2; i++) begin
      if (po_q[i] && !(i ? pulse_out_second : pulse_out_first)) begin
        chk(hi[i], ON);
        hi[i] = 0;
      end
      if ((i ? pulse_out_second : pulse_out_first) && !po_q[i]) begin
        if (rises[i] > 0) chk(since[i] >= PER, 32'h1);
        rises[i]++;
        since[i] = 0;
      end
      if (i ? pulse_out_second : pulse_out_first) hi[i]++;
      since[i]++;
    end
    po_q <= {pulse_out_second, pulse_out_first};
    if (press_evt != MPIO_PRESS_NONE) last_press = press_evt;
    if (join_immediate) n_jn++;
    if (join_delayed) n_jd++;
  end

  initial begin
    seed = 33;
    rstn = 1'b0;
    {psel, penable, pwrite, nav_button, menu_at_network_off, go} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    disp_inc = 3'h0;
    {k1, k2} = 16'h0000;
    {f1, f2} = {32'h1, 32'h1};
    last_press = MPIO_PRESS_NONE;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    chk(32'(svc_prim_addr), 32'h0);
    rdchk(REG_FACTOR1, 32'h1);
    rdchk(REG_FACTOR2, 32'h1);
    rdchk(REG_PRIM_ADDR, 32'h0);
    rdchk(REG_SEC_ADDR, SERIAL_NUM);
    chk(opt_bit_cycles, CLK_HZ / OPT_BAUD);
    chk(bus_bit_cycles, CLK_HZ / BUS_BAUD_HIGH);
    rdchk(8'h28, 32'h0);
    chk(32'(err), 32'h1);
    r = $random(seed);
    apb(1'b1, REG_PRIM_ADDR, {24'h0, r[7:0]});
    rdchk(REG_PRIM_ADDR, {24'h0, r[7:0]});
    chk(32'(svc_prim_addr), {24'h0, r[7:0]});
    apb(1'b1, REG_SEC_ADDR, r);
    rdchk(REG_SEC_ADDR, r);
    // The bus master only ever selects one of the two legal rates
    apb(1'b1, REG_BAUD, 32'h0);
    repeat (2) @(posedge clk);
    chk(bus_bit_cycles, CLK_HZ / BUS_BAUD_LOW);
    chk(opt_bit_cycles, CLK_HZ / OPT_BAUD);
    apb(1'b1, REG_BAUD, 32'h1);
    repeat (2) @(posedge clk);
    chk(bus_bit_cycles, CLK_HZ / BUS_BAUD_HIGH);
    for (int n = 0; n < 2; n++) begin
      k1 = 8'(($random(seed) & 15) + 1);
      k2 = 8'(($random(seed) & 15) + 1);
      if (n == 1) begin
        f1 = ($random(seed) & 3) + 1;
        f2 = ($random(seed) & 3) + 1;
        apb(1'b1, REG_FACTOR1, f1);
        apb(1'b1, REG_FACTOR2, f2);
        apb(1'b1, REG_AUX_TOT1, r);
        apb(1'b1, REG_AUX_TOT2, 32'h5A);
      end
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy1 || busy2) @(posedge clk);
      repeat (6) @(posedge clk);
      chk(aux_total_one, 32'(k1) / f1);
      rdchk(REG_AUX_TOT2, 32'(k2) / f2);
    end
    inc(3'h1, 3);
    inc(3'h4, 1);
    repeat (50) @(posedge clk);
    chk(rises[1], 32'h3);
    chk(rises[0], 32'h1);
    apb(1'b1, REG_CTRL, 32'h1);
    inc(3'h2, 2);
    inc(3'h4, 1);
    repeat (40) @(posedge clk);
    chk(rises[1], 32'h5);
    chk(rises[0], 32'h2);
    apb(1'b1, REG_JOIN, 32'h1);
    repeat (3) @(posedge clk);
    chk(n_jn, 32'h1);
    apb(1'b1, REG_JOIN, 32'h2);
    repeat (40) @(posedge clk);
    chk(n_jd, 32'h1);
    press(5);
    chk(32'(last_press), 32'(MPIO_PRESS_SHORT));
    menu_at_network_off <= 1'b1;
    press(30);
    chk(32'(last_press), 32'(MPIO_PRESS_LONG));
    press(30);
    chk(n_jn, 32'h2);
    menu_at_network_off <= 1'b0;
    repeat (3) @(posedge clk);
    menu_at_network_off <= 1'b1;
    press(30);
    press(5);
    press(30);
    repeat (40) @(posedge clk);
    chk(n_jd, 32'h2);
    results();
  end
endmodule // meter_pulse_io_and_comm_options_test
